// ===== inc/umc_pkg.sv
/*
  Package for the modem-control and line-status block: register offsets,
  field positions, reset values, interrupt layout and carrier structs.
  Assumes an 8-bit register port with one-cycle strobes.
*/
package umc_pkg;
  // register offsets
  localparam logic [2:0] OFS_IDENT = 3'h2;
  localparam logic [2:0] OFS_QUEUE = 3'h2;
  localparam logic [2:0] OFS_HSCTRL = 3'h4;
  localparam logic [2:0] OFS_LINE = 3'h5;
  localparam logic [2:0] OFS_HSCOND = 3'h6;
  localparam logic [2:0] OFS_EVSTAT = 3'h0;
  localparam logic [2:0] OFS_EVMASK = 3'h1;
  // handshake_control fields
  localparam int HC_TREADY = 0;
  localparam int HC_RTS = 1;
  localparam int HC_OUTA = 2;
  localparam int HC_OUTB = 3;
  localparam int HC_LOOP = 4;
  localparam logic [7:0] HC_WMASK = 8'h1F;
  localparam logic [7:0] HC_RESET = 8'h00;
  // line_condition fields
  localparam int LC_HOLDEMPTY = 5;
  localparam int LC_TXEMPTY = 6;
  localparam int LC_RXERR = 7;
  // queue_control fields
  localparam int QC_ENABLE = 0;
  // interrupt ident codes
  localparam logic [7:0] IDENT_NONE = 8'h01;
  localparam logic [7:0] IDENT_HOLD = 8'h02;
  // event status bits
  localparam int EV_HOLD = 0;
  localparam int EV_RXERR = 1;
  localparam int EV_TXEMPTY = 2;
  localparam int EV_W = 3;
  localparam logic [7:0] REG_ZERO = 8'h00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umc_bus_t;

  // handshake pins, active low
  typedef struct packed {
    logic ctsN;
    logic dsrN;
    logic ringN;
    logic carrierN;
  } umc_hsin_t;

  // transmit/receive datapath status from the channel
  typedef struct packed {
    logic holdingFull;
    logic shiftBusy;
    logic txFifoEmpty;
    logic txFifoWrite;
    logic holdToShift;
    logic rxErrPresent;
  } umc_txstat_t;
endpackage

// ===== verif/tb.sv
/*
  Self-checking bench for the modem-control and line-status block.
  Assumes one 125 MHz clock; read results are checked through a queue.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, reset, txShiftOut, rxPin, portIrq, ring, carrier, rdPend, r, lp;
  logic rxShiftIn, serialTxPin, rtsN, termReadyN, fifoMode, portIrqOut, eventIrq;
  logic [7:0] rdata, v;
  logic [3:0] hsCond, hs;
  logic [15:0] note;
  logic [15:0] q[$];
  int n_errors, checked;
  umc_pkg::umc_bus_t bus;
  umc_pkg::umc_txstat_t txStat;
  umc_pkg::umc_hsin_t hsIn;

  umc_line_ctrl i_dut (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata_reg(rdata),
    .txShiftOut(txShiftOut), .rxPin(rxPin), .txStat(txStat), .portIrq(portIrq),
    .rxShiftIn_reg(rxShiftIn), .hsIn(hsIn), .serialTxPin_reg(serialTxPin),
    .rtsN_reg(rtsN), .termReadyN_reg(termReadyN), .hsCond_reg(hsCond),
    .fifoMode_reg(fifoMode), .portIrqOut_reg(portIrqOut), .eventIrq_reg(eventIrq));
  umc_modem_model i_modem (.core_clk(core_clk), .rtsN(rtsN), .termReadyN(termReadyN),
    .ringReq(ring), .carrierReq(carrier), .hsIn(hsIn));

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmpb(input string nm, input logic e, input logic g);
    cmp(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // m selects the bits compared; exp already masked
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e});
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(negedge core_clk) begin
    if (rdPend) begin
      note = q.pop_front();
      cmp("rdata", note[7:0], rdata & note[15:8]);
    end
    rdPend = bus.rd;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    reset = 1;
    bus = '0;
    txStat = '0;
    txStat.txFifoEmpty = 1;
    {txShiftOut, rxPin, portIrq, ring, carrier} = 5'h18;
    n_errors = 0;
    checked = 0;
    void'($urandom(9315));
    repeat (10) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    rd(umc_pkg::OFS_LINE, 8'h60, 8'hE0);
    rd(umc_pkg::OFS_HSCTRL, 8'h00, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[4] = i[0];
      lp = v[4];
      r = 1'($urandom);
      txShiftOut <= r;
      rxPin <= ~r;
      {portIrq, ring, carrier} <= 3'($urandom);
      wr(umc_pkg::OFS_HSCTRL, v);
      idle(4);
      cmpb("txPin", lp | r, serialTxPin);
      cmpb("rtsN", lp | ~v[1], rtsN);
      cmpb("termReadyN", lp | ~v[0], termReadyN);
      cmpb("rxShiftIn", lp ? r : ~r, rxShiftIn);
      cmpb("portIrqOut", portIrq & v[3], portIrqOut);
      hs = lp ? {v[3], v[2], v[0], v[1]} : {carrier, ring, v[0], v[1]};
      cmp("hsCond", {4'h0, hs}, {4'h0, hsCond});
      rd(umc_pkg::OFS_HSCOND, {hs, 4'h0}, 8'hF0);
      rd(umc_pkg::OFS_HSCTRL, v & 8'h1F, 8'hFF);
    end
    txStat.rxErrPresent <= 1;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h00, 8'h80);
    wr(umc_pkg::OFS_QUEUE, 8'h01);
    idle(2);
    cmpb("fifoMode", 1'b1, fifoMode);
    rd(umc_pkg::OFS_LINE, 8'h80, 8'h80);
    rd(umc_pkg::OFS_LINE, 8'h80, 8'h80);
    txStat.rxErrPresent <= 0;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h80, 8'h80);
    rd(umc_pkg::OFS_LINE, 8'h00, 8'h80);
    txStat.txFifoEmpty <= 0;
    txStat.txFifoWrite <= 1;
    idle(1);
    txStat.txFifoWrite <= 0;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h00, 8'h60);
    txStat.txFifoEmpty <= 1;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h60, 8'h60);
    wr(umc_pkg::OFS_QUEUE, 8'h00);
    txStat.holdingFull <= 1;
    idle(2);
    rd(umc_pkg::OFS_IDENT, umc_pkg::IDENT_HOLD, 8'hFF);
    wr(umc_pkg::OFS_EVSTAT, 8'h07);
    rd(umc_pkg::OFS_LINE, 8'h00, 8'h60);
    txStat.holdingFull <= 0;
    txStat.shiftBusy <= 1;
    txStat.holdToShift <= 1;
    idle(1);
    txStat.holdToShift <= 0;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h20, 8'h60);
    rd(umc_pkg::OFS_IDENT, umc_pkg::IDENT_HOLD, 8'hFF);
    rd(umc_pkg::OFS_IDENT, umc_pkg::IDENT_NONE, 8'hFF);
    rd(umc_pkg::OFS_EVSTAT, 8'h01, 8'h07);
    idle(1);
    cmpb("eventIrq", 1'b0, eventIrq);
    wr(umc_pkg::OFS_EVMASK, 8'h01);
    idle(2);
    cmpb("eventIrq", 1'b1, eventIrq);
    wr(umc_pkg::OFS_EVSTAT, 8'h01);
    idle(2);
    cmpb("eventIrq", 1'b0, eventIrq);
    rd(3'h7, 8'h00, 8'hFF);
    txStat.shiftBusy <= 0;
    idle(2);
    rd(umc_pkg::OFS_LINE, 8'h60, 8'h60);
    rd(umc_pkg::OFS_EVSTAT, 8'h04, 8'h07);
    idle(3);
    end_sim();
  end
endmodule
`default_nettype wire

// ===== verif/umc_modem_model.sv
/*
  Behavioural modem on the handshake lines: clear-to-send echoes
  request-to-send two cycles late, data-set-ready follows terminal ready,
  ring and carrier come from the bench.
  Assumes active-low pins and one core_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module umc_modem_model (
  // clock
  input wire logic core_clk,
  // lines from the port
  input wire logic rtsN,
  input wire logic termReadyN,
  // bench controls
  input wire logic ringReq,
  input wire logic carrierReq,
  // lines to the port
  output var umc_pkg::umc_hsin_t hsIn
);
  logic [1:0] rtsDly;

  // slow answer to a send request
  always_ff @(posedge core_clk) begin
    rtsDly <= {rtsDly[0], rtsN};
  end

  always_comb begin
    hsIn.ctsN = rtsDly[1];
    hsIn.dsrN = termReadyN;
    hsIn.ringN = ~ringReq;
    hsIn.carrierN = ~carrierReq;
  end
endmodule
`default_nettype wire

// ===== verilog/umc_line_ctrl.sv
/*
  Modem-control and transmit line-status logic of one serial channel:
  handshake_control register, loopback steering, interrupt gating,
  line_condition bits, event status with mask and one interrupt line.
  Assumes the channel's shifters, FIFOs and interrupt source sit outside
  and report through umc_txstat_t; all inputs are synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module umc_line_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire umc_pkg::umc_bus_t bus,
  output logic [7:0] rdata_reg,
  // channel datapath
  input wire logic txShiftOut,
  input wire logic rxPin,
  input wire umc_pkg::umc_txstat_t txStat,
  input wire logic portIrq,
  output logic rxShiftIn_reg,
  // serial and handshake pins
  input wire umc_pkg::umc_hsin_t hsIn,
  output logic serialTxPin_reg,
  output logic rtsN_reg,
  output logic termReadyN_reg,
  // status to the rest of the channel
  output logic [3:0] hsCond_reg,
  output logic fifoMode_reg,
  // interrupts
  output logic portIrqOut_reg,
  output logic eventIrq_reg
);
  logic [7:0] hsCtrl_reg;
  logic holdEmpty_reg;
  logic holdEmpty_next;
  logic txEmpty_reg;
  logic rxErr_reg;
  logic rxErr_next;
  logic identPend_reg;
  logic [umc_pkg::EV_W-1:0] evMask_reg;
  logic [umc_pkg::EV_W-1:0] evStat;
  logic [umc_pkg::EV_W-1:0] evSet;
  logic [7:0] lineVal;
  logic loopOn;
  logic wrCtrl;
  logic wrQueue;
  logic rdLine;
  logic rdIdent;
  logic holdRise;
  logic txEmptyRise;

  assign loopOn = hsCtrl_reg[umc_pkg::HC_LOOP];
  assign wrCtrl = bus.wr && bus.addr == umc_pkg::OFS_HSCTRL;
  assign wrQueue = bus.wr && bus.addr == umc_pkg::OFS_QUEUE;
  assign rdLine = bus.rd && bus.addr == umc_pkg::OFS_LINE;
  assign rdIdent = bus.rd && bus.addr == umc_pkg::OFS_IDENT;

  // control register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hsCtrl_reg <= umc_pkg::HC_RESET;
    end else if (wrCtrl) begin
      hsCtrl_reg <= bus.wdata & umc_pkg::HC_WMASK;
    end
  end

  // fifo mode from queue control enable bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fifoMode_reg <= 1'b0;
    end else if (wrQueue) begin
      fifoMode_reg <= bus.wdata[umc_pkg::QC_ENABLE];
    end
  end

  // serial path steering
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serialTxPin_reg <= 1'b1;
      rxShiftIn_reg <= 1'b1;
    end else begin
      serialTxPin_reg <= loopOn ? 1'b1 : txShiftOut;
      rxShiftIn_reg <= loopOn ? txShiftOut : rxPin;
    end
  end

  // handshake pins and condition bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rtsN_reg <= 1'b1;
      termReadyN_reg <= 1'b1;
      hsCond_reg <= 4'h0;
    end else if (loopOn) begin
      rtsN_reg <= 1'b1;
      termReadyN_reg <= 1'b1;
      // order: carrier, ring, data-set-ready, clear-to-send
      hsCond_reg <= {hsCtrl_reg[umc_pkg::HC_OUTB], hsCtrl_reg[umc_pkg::HC_OUTA],
                     hsCtrl_reg[umc_pkg::HC_TREADY], hsCtrl_reg[umc_pkg::HC_RTS]};
    end else begin
      rtsN_reg <= ~hsCtrl_reg[umc_pkg::HC_RTS];
      termReadyN_reg <= ~hsCtrl_reg[umc_pkg::HC_TREADY];
      hsCond_reg <= ~{hsIn.carrierN, hsIn.ringN, hsIn.dsrN, hsIn.ctsN};
    end
  end

  // port interrupt gate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      portIrqOut_reg <= 1'b0;
    end else begin
      portIrqOut_reg <= portIrq && hsCtrl_reg[umc_pkg::HC_OUTB];
    end
  end

  // holding-register-empty
  always_comb begin
    holdEmpty_next = holdEmpty_reg;
    if (fifoMode_reg) begin
      holdEmpty_next = txStat.txFifoEmpty && !txStat.txFifoWrite;
    end else if (txStat.holdToShift) begin
      holdEmpty_next = 1'b1;
    end else if (txStat.holdingFull) begin
      holdEmpty_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      holdEmpty_reg <= 1'b1;
    end else begin
      holdEmpty_reg <= holdEmpty_next;
    end
  end

  assign holdRise = holdEmpty_next && !holdEmpty_reg;

  // pending ident interrupt; a new rise wins over the clearing read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      identPend_reg <= 1'b0;
    end else if (holdRise) begin
      identPend_reg <= 1'b1;
    end else if (rdIdent) begin
      identPend_reg <= 1'b0;
    end
  end

  // transmitter empty
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txEmpty_reg <= 1'b1;
    end else begin
      txEmpty_reg <= holdEmpty_next && !txStat.shiftBusy;
    end
  end

  // receive fifo error
  always_comb begin
    rxErr_next = rxErr_reg;
    if (!fifoMode_reg) begin
      rxErr_next = 1'b0;
    end else if (txStat.rxErrPresent && !rxErr_reg) begin
      rxErr_next = 1'b1;
    end else if (rdLine) begin
      rxErr_next = txStat.rxErrPresent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxErr_reg <= 1'b0;
    end else begin
      rxErr_reg <= rxErr_next;
    end
  end

  assign lineVal = {rxErr_reg, txEmpty_reg, holdEmpty_reg, 5'h00};

  // event status bits
  // tx-empty event on the rising edge of the status bit
  assign txEmptyRise = holdEmpty_next && !txStat.shiftBusy && !txEmpty_reg;
  assign evSet = {txEmptyRise, rxErr_next && !rxErr_reg, holdRise};

  genvar gi;
  generate
    for (gi = 0; gi < umc_pkg::EV_W; gi++) begin : gEv
      umc_sync_bit uEv (
        .core_clk(core_clk),
        .reset(reset),
        .setEv(evSet[gi]),
        .clrEv(bus.wr && bus.addr == umc_pkg::OFS_EVSTAT && bus.wdata[gi]),
        .flag_reg(evStat[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      evMask_reg <= '0;
    end else if (bus.wr && bus.addr == umc_pkg::OFS_EVMASK) begin
      evMask_reg <= bus.wdata[umc_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      eventIrq_reg <= 1'b0;
    end else begin
      eventIrq_reg <= |(evStat & evMask_reg);
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_reg <= umc_pkg::REG_ZERO;
    end else if (bus.rd) begin
      case (bus.addr)
        umc_pkg::OFS_HSCTRL: rdata_reg <= hsCtrl_reg;
        umc_pkg::OFS_LINE: rdata_reg <= lineVal;
        umc_pkg::OFS_IDENT: rdata_reg <= identPend_reg ? umc_pkg::IDENT_HOLD
                                                       : umc_pkg::IDENT_NONE;
        umc_pkg::OFS_HSCOND: rdata_reg <= {hsCond_reg, 4'h0};
        umc_pkg::OFS_EVSTAT: rdata_reg <= {5'h00, evStat};
        umc_pkg::OFS_EVMASK: rdata_reg <= {5'h00, evMask_reg};
        default: rdata_reg <= umc_pkg::REG_ZERO;
      endcase
    end else begin
      rdata_reg <= umc_pkg::REG_ZERO;
    end
  end

  // checks
  a_loop_marking: assert property (@(posedge core_clk) disable iff (reset)
    $past(loopOn) |-> serialTxPin_reg) else $error("tx pin not marking in loopback");
  a_loop_feed: assert property (@(posedge core_clk) disable iff (reset)
    $past(loopOn) |-> rxShiftIn_reg == $past(txShiftOut))
    else $error("loopback feed wrong");
  a_loop_pins: assert property (@(posedge core_clk) disable iff (reset)
    $past(loopOn) |-> rtsN_reg && termReadyN_reg) else $error("pins active in loopback");
  a_loop_cond: assert property (@(posedge core_clk) disable iff (reset)
    $past(loopOn) |-> hsCond_reg == {$past(hsCtrl_reg[3]), $past(hsCtrl_reg[2]),
                                     $past(hsCtrl_reg[0]), $past(hsCtrl_reg[1])})
    else $error("loop status routing wrong");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
    portIrqOut_reg |-> $past(hsCtrl_reg[3] && portIrq)) else $error("irq not gated");
  a_rts_pin: assert property (@(posedge core_clk) disable iff (reset)
    !$past(loopOn) |-> rtsN_reg == !$past(hsCtrl_reg[1])) else $error("rts pin wrong");
  a_ready_pin: assert property (@(posedge core_clk) disable iff (reset)
    !$past(loopOn) |-> termReadyN_reg == !$past(hsCtrl_reg[0])) else $error("ready pin wrong");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
    hsCtrl_reg[7:5] == 3'h0) else $error("reserved bits set");
  a_rxerr_mode: assert property (@(posedge core_clk) disable iff (reset)
    !fifoMode_reg |=> !rxErr_reg) else $error("rx error outside fifo mode");
  a_hold_move: assert property (@(posedge core_clk) disable iff (reset)
    !fifoMode_reg && txStat.holdToShift |=> holdEmpty_reg) else $error("hold empty not set");
  a_ident_pend: assert property (@(posedge core_clk) disable iff (reset)
    holdRise |=> identPend_reg) else $error("ident not pending");
  a_fifo_write: assert property (@(posedge core_clk) disable iff (reset)
    fifoMode_reg && txStat.txFifoWrite |=> !holdEmpty_reg) else $error("hold empty on write");

  c_loop_on: cover property (@(posedge core_clk) disable iff (reset) $rose(loopOn));
  c_ident_clear: cover property (@(posedge core_clk) disable iff (reset)
    identPend_reg && rdIdent ##1 !identPend_reg);
  c_rxerr_clear: cover property (@(posedge core_clk) disable iff (reset) $fell(rxErr_reg));
  c_irq_out: cover property (@(posedge core_clk) disable iff (reset) $rose(portIrqOut_reg));
endmodule
`default_nettype wire

// ===== verilog/umc_sync_bit.sv
/*
  Sticky event bit: set by hardware, cleared by a write of one.
  Assumes set and clear are synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module umc_sync_bit (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic setEv,
  input wire logic clrEv,
  // state
  output logic flag_reg
);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (setEv) begin
      flag_reg <= 1'b1;
    end else if (clrEv) begin
      flag_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire
